// ===== hdl/gct_timer.v
// Gated and capture/compare 16-bit timer with byte register file
//
// How it works
// - Software-written count is the start value only for the first pass after enable.
// - In gated mode every reload restarts the counter at 0001H.
// - Reload value is the 16-bit pair of reload high and low bytes.
// - Gated interrupt on deassertion and reload, config field may limit to one.
// - Capture/compare counter idles until the first qualifying input edge.
// - Polarity bit selects rising or falling edges in capture/compare mode.
// - Capture/compare counts prescaled system clock, not the input pin.
// - Both alternate selects set put complemented timer output on port A bit 0.
// - Later edges capture count, interrupt, restart at 0001H, set cause flag.
// - Compare match interrupts, restarts at 0001H and clears the cause flag.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "gct_consts.vh"
module gct_timer #(
  parameter PRES_WIDTH = 7
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire [11:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  // Port A bit 0 pin
  input wire portA0In,
  output reg portA0Out,
  output reg portA0Oe,
  // Interrupt
  output reg timerIrq
);

  // Register file state
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg [7:0] rldHi_r;
  reg [7:0] rldLo_r;
  reg [15:0] pwm_r;
  reg [15:0] pwm_nxt;
  reg [1:0] irqCfg_r;
  reg cause_r;
  reg cause_nxt;
  reg [7:0] ctl1_r;
  reg [`GCT_ST_WIDTH-1:0] stat_r;
  reg [`GCT_ST_WIDTH-1:0] mask_r;
  reg [7:0] altLow_r;
  reg [7:0] altHigh_r;

  // Timer state
  reg armed_r;
  reg armed_nxt;
  reg timerOut_r;
  reg timerOut_nxt;
  reg inSync1_r;
  reg inSync2_r;
  reg inPrev_r;
  reg [`GCT_ST_WIDTH-1:0] evSet;

  wire [15:0] reloadVal;
  wire timerEn;
  wire inPol;
  wire [2:0] mode;
  wire pinIsInput;
  wire tinLevel;
  wire asserted;
  wire assertedPrev;
  wire qualEdge;
  wire deassertEdge;
  wire presTick;
  wire [16:0] stepRes;
  wire cfgReload;
  wire cfgDeassert;
  wire [`GCT_ST_WIDTH-1:0] statClr;

  // Count step: bit 16 flags a match, low bits are the next count
  function [16:0] countStep;
    input [15:0] cur;
    input [15:0] limit;
    begin
      if (cur == limit) begin
        countStep = {1'b1, `GCT_RESTART};
      end else begin
        countStep = {1'b0, cur + 16'h0001};
      end
    end
  endfunction

  // Address match helper, shared by every register write
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  assign reloadVal = {rldHi_r, rldLo_r};
  assign timerEn = ctl1_r[`GCT_CTL1_EN];
  assign inPol = ctl1_r[`GCT_CTL1_POL];
  assign mode = ctl1_r[`GCT_CTL1_MODE_HI:`GCT_CTL1_MODE_LO];
  assign stepRes = countStep(cnt_r, reloadVal);

  // Pin feeds the timer only in its input function
  assign pinIsInput = ~altLow_r[0] & ~altHigh_r[0];
  assign tinLevel = pinIsInput & inSync2_r;
  assign asserted = tinLevel ^ inPol;
  assign assertedPrev = inPrev_r ^ inPol;
  // Polarity 0 takes rising edges, 1 takes falling edges
  assign qualEdge = asserted & ~assertedPrev;
  assign deassertEdge = ~asserted & assertedPrev;

  // Interrupt event filter for gated mode
  assign cfgReload = (irqCfg_r != `GCT_CFG_DEASSERT);
  assign cfgDeassert = (irqCfg_r != `GCT_CFG_RELOAD);

  // Write-one-to-clear mask for the status register
  assign statClr = (regWrite && hit(regAddr, `GCT_OFF_IRQ_STAT)) ?
                   regWdata[`GCT_ST_WIDTH-1:0] : {`GCT_ST_WIDTH{1'b0}};

  gct_prescaler #(
    .WIDTH(PRES_WIDTH)
  ) u_pres (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(timerEn),
    .divCode(ctl1_r[`GCT_CTL1_PRES_HI:`GCT_CTL1_PRES_LO]),
    .tick(presTick)
  );

  // Pin synchroniser and edge history; first stage feeds only the second
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      inSync1_r <= 1'b0;
      inSync2_r <= 1'b0;
      inPrev_r <= 1'b0;
    end else begin
      inSync1_r <= portA0In;
      inSync2_r <= inSync1_r;
      inPrev_r <= tinLevel;
    end
  end

  // Counting, capture and compare behaviour per mode
  always @* begin
    cnt_nxt = cnt_r;
    pwm_nxt = pwm_r;
    cause_nxt = cause_r;
    armed_nxt = armed_r;
    timerOut_nxt = timerOut_r;
    evSet = {`GCT_ST_WIDTH{1'b0}};
    if (!timerEn) begin
      // Disabled: count keeps the software start value for the next pass
      armed_nxt = 1'b0;
    end else begin
      case (mode)
        `GCT_MODE_GATED: begin
          // Count holds when not asserted, so the software value is kept
          if (presTick && asserted) begin
            cnt_nxt = stepRes[15:0];
            if (stepRes[16]) begin
              // Every later pass starts from the restart value
              cnt_nxt = `GCT_RESTART;
              timerOut_nxt = ~timerOut_r;
              evSet[`GCT_ST_RELOAD] = cfgReload;
            end
          end
          if (deassertEdge) begin
            evSet[`GCT_ST_DEASSERT] = cfgDeassert;
          end
        end
        `GCT_MODE_CAPCMP: begin
          if (qualEdge && !armed_r) begin
            armed_nxt = 1'b1;
          end else if (qualEdge) begin
            // Capture outranks a compare in the same cycle
            pwm_nxt = cnt_r;
            cnt_nxt = `GCT_RESTART;
            cause_nxt = 1'b1;
            evSet[`GCT_ST_CAPTURE] = 1'b1;
          end else if (armed_r && presTick) begin
            cnt_nxt = stepRes[15:0];
            if (stepRes[16]) begin
              cause_nxt = 1'b0;
              timerOut_nxt = ~timerOut_r;
              evSet[`GCT_ST_RELOAD] = 1'b1;
            end
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
    // Software byte writes override the hardware count
    if (regWrite && hit(regAddr, `GCT_OFF_CNT_HI)) begin
      cnt_nxt[15:8] = regWdata;
    end
    if (regWrite && hit(regAddr, `GCT_OFF_CNT_LO)) begin
      cnt_nxt[7:0] = regWdata;
    end
    if (regWrite && hit(regAddr, `GCT_OFF_PWM_HI)) begin
      pwm_nxt[15:8] = regWdata;
    end
    if (regWrite && hit(regAddr, `GCT_OFF_PWM_LO)) begin
      pwm_nxt[7:0] = regWdata;
    end
  end

  // Timer state registers
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= {`GCT_RST_CNT_HI, `GCT_RST_CNT_LO};
      pwm_r <= {`GCT_RST_PWM, `GCT_RST_PWM};
      cause_r <= 1'b0;
      armed_r <= 1'b0;
      timerOut_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pwm_r <= pwm_nxt;
      cause_r <= cause_nxt;
      armed_r <= armed_nxt;
      timerOut_r <= timerOut_nxt;
    end
  end

  // Software-only configuration registers
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rldHi_r <= `GCT_RST_RLD;
      rldLo_r <= `GCT_RST_RLD;
      irqCfg_r <= 2'h0;
      ctl1_r <= `GCT_RST_CTL;
      mask_r <= {`GCT_ST_WIDTH{1'b0}};
      altLow_r <= `GCT_RST_BYTE;
      altHigh_r <= `GCT_RST_BYTE;
    end else if (regWrite) begin
      if (hit(regAddr, `GCT_OFF_RLD_HI)) begin
        rldHi_r <= regWdata;
      end
      if (hit(regAddr, `GCT_OFF_RLD_LO)) begin
        rldLo_r <= regWdata;
      end
      if (hit(regAddr, `GCT_OFF_CTL0)) begin
        irqCfg_r <= regWdata[`GCT_CTL0_CFG_HI:`GCT_CTL0_CFG_LO];
      end
      if (hit(regAddr, `GCT_OFF_CTL1)) begin
        ctl1_r <= regWdata;
      end
      if (hit(regAddr, `GCT_OFF_IRQ_MASK)) begin
        mask_r <= regWdata[`GCT_ST_WIDTH-1:0];
      end
      if (hit(regAddr, `GCT_OFF_ALT_LOW)) begin
        altLow_r <= regWdata;
      end
      if (hit(regAddr, `GCT_OFF_ALT_HIGH)) begin
        altHigh_r <= regWdata;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= {`GCT_ST_WIDTH{1'b0}};
      timerIrq <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~statClr) | evSet;
      timerIrq <= |(((stat_r & ~statClr) | evSet) & mask_r);
    end
  end

  // Pin drive: complemented output only with both selects set
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      portA0Out <= 1'b1;
      portA0Oe <= 1'b0;
    end else begin
      portA0Out <= ~timerOut_nxt;
      portA0Oe <= altLow_r[0] & altHigh_r[0];
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (!regRead) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        `GCT_OFF_CNT_HI: regRdata <= cnt_r[15:8];
        `GCT_OFF_CNT_LO: regRdata <= cnt_r[7:0];
        `GCT_OFF_RLD_HI: regRdata <= rldHi_r;
        `GCT_OFF_RLD_LO: regRdata <= rldLo_r;
        `GCT_OFF_PWM_HI: regRdata <= pwm_r[15:8];
        `GCT_OFF_PWM_LO: regRdata <= pwm_r[7:0];
        `GCT_OFF_CTL0: regRdata <= {3'h0, irqCfg_r, 2'h0, cause_r};
        `GCT_OFF_CTL1: regRdata <= ctl1_r;
        `GCT_OFF_IRQ_STAT: regRdata <= {5'h00, stat_r};
        `GCT_OFF_IRQ_MASK: regRdata <= {5'h00, mask_r};
        `GCT_OFF_ALT_LOW: regRdata <= altLow_r;
        `GCT_OFF_ALT_HIGH: regRdata <= altHigh_r;
        default: regRdata <= 8'h00;
      endcase
    end
  end

endmodule // gct_timer

// ===== hdl/gct_consts.vh
// Register offsets, field positions, reset values and codes of the timer
`ifndef GCT_CONSTS_VH
`define GCT_CONSTS_VH

`define GCT_OFF_CNT_HI 12'hf00
`define GCT_OFF_CNT_LO 12'hf01
`define GCT_OFF_RLD_HI 12'hf02
`define GCT_OFF_RLD_LO 12'hf03
`define GCT_OFF_PWM_HI 12'hf04
`define GCT_OFF_PWM_LO 12'hf05
`define GCT_OFF_CTL0 12'hf06
`define GCT_OFF_CTL1 12'hf07
`define GCT_OFF_IRQ_STAT 12'hf08
`define GCT_OFF_IRQ_MASK 12'hf09
`define GCT_OFF_ALT_LOW 12'hf0a
`define GCT_OFF_ALT_HIGH 12'hf0b

`define GCT_RST_CNT_HI 8'h00
`define GCT_RST_CNT_LO 8'h01
`define GCT_RST_RLD 8'hff
`define GCT_RST_PWM 8'h00
`define GCT_RST_CTL 8'h00
`define GCT_RST_BYTE 8'h00
`define GCT_RESTART 16'h0001

`define GCT_CTL1_EN 7
`define GCT_CTL1_POL 6
`define GCT_CTL1_PRES_HI 5
`define GCT_CTL1_PRES_LO 3
`define GCT_CTL1_MODE_HI 2
`define GCT_CTL1_MODE_LO 0
`define GCT_CTL0_CFG_HI 4
`define GCT_CTL0_CFG_LO 3
`define GCT_CTL0_CAUSE 0

`define GCT_MODE_GATED 3'h6
`define GCT_MODE_CAPCMP 3'h7

`define GCT_CFG_BOTH 2'h0
`define GCT_CFG_BOTH_ALT 2'h1
`define GCT_CFG_DEASSERT 2'h2
`define GCT_CFG_RELOAD 2'h3

`define GCT_ST_RELOAD 0
`define GCT_ST_DEASSERT 1
`define GCT_ST_CAPTURE 2
`define GCT_ST_WIDTH 3

`endif

// ===== hdl/gct_prescaler.v
// Power-of-two prescaler giving a one-cycle count tick
`timescale 1ns/10ps
module gct_prescaler #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Control
  input wire run,
  input wire [2:0] divCode,
  // Tick out
  output reg tick
);

  reg [WIDTH-1:0] div_r;
  wire [WIDTH-1:0] divMask;

  // Mask of low bits that must all be one for a tick
  assign divMask = ~({WIDTH{1'b1}} << divCode);

  // Free divider, cleared while stopped so each run starts aligned
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      div_r <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else begin
      div_r <= div_r + {{(WIDTH-1){1'b0}}, 1'b1};
      tick <= ((div_r & divMask) == divMask);
    end
  end

endmodule // gct_prescaler

// ===== verification/gct_timer_chk.sv
// Port-level assertions for the timer
`timescale 1ns/10ps
module gct_timer_chk (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire [11:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdata,
  // Pin and interrupt
  input wire portA0In,
  input wire portA0Out,
  input wire portA0Oe,
  input wire timerIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  reg [7:0] ctl_r;
  reg [7:0] rhi_r;
  reg [7:0] rlo_r;
  reg maskOff_r;
  reg altA_r;
  reg altB_r;
  wire altOn = altA_r & altB_r;
  // Shadows of software-owned bytes
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= 8'h00;
      rhi_r <= 8'hff;
      rlo_r <= 8'hff;
      maskOff_r <= 1'b1;
      altA_r <= 1'b0;
      altB_r <= 1'b0;
    end else if (regWrite) begin
      case (regAddr)
        12'hf02: rhi_r <= regWdata;
        12'hf03: rlo_r <= regWdata;
        12'hf07: ctl_r <= regWdata;
        12'hf09: maskOff_r <= (regWdata[2:0] == 3'h0);
        12'hf0a: altA_r <= regWdata[0];
        12'hf0b: altB_r <= regWdata[0];
        default: ;
      endcase
    end
  end
  chk_rdata_idle: assert property (regRdata != 8'h00 |-> $past(regRead))
    else $error("read data outside a read answer");
  chk_unmapped_zero: assert property (
    regRead && (regAddr < 12'hf00 || regAddr > 12'hf0b) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctl_read: assert property (regRead && regAddr == 12'hf07 |=> regRdata == ctl_r)
    else $error("control byte read wrong");
  chk_rldhi_read: assert property (regRead && regAddr == 12'hf02 |=> regRdata == rhi_r)
    else $error("reload high read wrong");
  chk_rldlo_read: assert property (regRead && regAddr == 12'hf03 |=> regRdata == rlo_r)
    else $error("reload low read wrong");
  chk_irq_masked: assert property (maskOff_r && $past(maskOff_r) |-> !timerIrq)
    else $error("interrupt with all masked");
  chk_pin_on: assert property (altOn && $past(altOn) |-> portA0Oe)
    else $error("pin not driven");
  chk_pin_off: assert property (!altOn && !$past(altOn) |-> !portA0Oe)
    else $error("pin driven wrongly");
  // A stopped timer makes no output events, so the pin value holds
  chk_out_still: assert property (!ctl_r[7] && !$past(ctl_r[7]) |-> $stable(portA0Out))
    else $error("output moved while timer stopped");
endmodule // gct_timer_chk

// ===== verification/gct_pin_model.sv
// External party driving the timer input pin
`timescale 1ns/10ps
module gct_pin_model (
  // Clock
  input wire sys_clk,
  // Pin drive
  output reg pinLevel,
  output reg pinOe
);
  // Released at start, pull-down sets the idle level
  initial begin
    pinLevel = 1'b0;
    pinOe = 1'b0;
  end
  // Level changes just after an edge, held till next call
  task drive(input logic lvl);
    @(posedge sys_clk);
    pinLevel <= lvl;
    pinOe <= 1'b1;
  endtask
  // Let go so the design may own the pin
  task letgo;
    @(posedge sys_clk);
    pinOe <= 1'b0;
  endtask
endmodule // gct_pin_model

// ===== verification/test_gated_capture_timer.sv
// Self-checking bench for the gated capture timer
`timescale 1ns/10ps
module test_gated_capture_timer;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg [11:0] regAddr = 12'h000;
  reg [7:0] regWdata = 8'h00;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  wire [7:0] regRdata;
  wire portA0Out, portA0Oe, timerIrq, pinLevel, pinOe;
  // Pull-down keeps the pin low when nobody drives it
  wire pinWire = portA0Oe ? portA0Out : (pinOe ? pinLevel : 1'b0);
  integer errorCnt = 0;
  integer comparisons = 0;
  integer i;
  reg [7:0] d;
  reg [7:0] e;
  always #4 sys_clk = ~sys_clk;
  gct_timer u_gct_timer (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .portA0In(pinWire), .portA0Out(portA0Out), .portA0Oe(portA0Oe), .timerIrq(timerIrq));
  gct_pin_model u_gct_pin_model (.sys_clk(sys_clk), .pinLevel(pinLevel), .pinOe(pinOe));
  // Compare and count
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errorCnt = errorCnt + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input [11:0] a, input [7:0] w);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= w;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input [11:0] a, output [7:0] r);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 r = regRdata;
  endtask
  task irqIs(input logic v);
    cyc(2);
    // Look after the edge so the value launched on it has settled
    #1;
    chk("irq", {7'h0, timerIrq}, {7'h0, v});
  endtask
  initial begin
    cyc(12);
    rstn <= 1'b1;
    for (i = 0; i < 12; i = i + 1) begin
      rd(12'hf00 + i[11:0], d);
      e = (i == 1) ? 8'h01 : (i == 2 || i == 3) ? 8'hff : 8'h00;
      chk("reset value", d, e);
    end
    rd(12'he00, d);
    chk("unmapped", d, 8'h00);
    $display("done: reset values");
    // Gated pass with slow prescale
    wr(12'hf09, 8'h07);
    wr(12'hf07, 8'h3e);
    wr(12'hf01, 8'h02);
    wr(12'hf02, 8'h00);
    wr(12'hf03, 8'h03);
    wr(12'hf07, 8'hbe);
    rd(12'hf01, d);
    chk("start count", d, 8'h02);
    u_gct_pin_model.drive(1'b1);
    for (i = 0; i < 3000 && timerIrq !== 1'b1; i = i + 1) @(posedge sys_clk);
    if (timerIrq !== 1'b1) begin
      chk("irq wait", 8'h00, 8'h01);
      tally_and_finish;
    end
    rd(12'hf01, d);
    chk("restart", d, 8'h01);
    u_gct_pin_model.drive(1'b0);
    cyc(300);
    rd(12'hf01, d);
    chk("frozen", d, 8'h01);
    rd(12'hf08, d);
    chk("gated status", d, 8'h03);
    wr(12'hf08, 8'h07);
    irqIs(1'b0);
    $display("done: gated");
    // One reload toggled the output, so the complement is low
    u_gct_pin_model.letgo;
    wr(12'hf0a, 8'h01);
    cyc(3);
    chk("one select", {7'h0, portA0Oe}, 8'h00);
    wr(12'hf0b, 8'h01);
    cyc(3);
    chk("pin out", {6'h0, portA0Oe, pinWire}, 8'h02);
    wr(12'hf0a, 8'h00);
    // Both selects must be clear again or the pin no longer feeds the timer
    wr(12'hf0b, 8'h00);
    $display("done: pin function");
    // Every event selection
    for (i = 0; i < 4; i = i + 1) begin
      wr(12'hf07, 8'h06);
      wr(12'hf03, 8'h10);
      wr(12'hf01, 8'h01);
      wr(12'hf06, {3'h0, i[1:0], 3'h0});
      wr(12'hf08, 8'h07);
      wr(12'hf07, 8'h86);
      u_gct_pin_model.drive(1'b1);
      cyc(40);
      u_gct_pin_model.drive(1'b0);
      cyc(10);
      rd(12'hf08, d);
      chk("event select", d, {6'h0, i != 3, i != 2});
    end
    irqIs(1'b1);
    wr(12'hf09, 8'h00);
    irqIs(1'b0);
    wr(12'hf09, 8'h07);
    irqIs(1'b1);
    wr(12'hf08, 8'h07);
    irqIs(1'b0);
    $display("done: event select");
    // Capture then compare, both polarities; middle edge is the wrong way
    for (i = 0; i < 2; i = i + 1) begin
      wr(12'hf07, {1'b0, i[0], 6'h07});
      wr(12'hf02, 8'hff);
      wr(12'hf03, 8'hff);
      wr(12'hf01, 8'h01);
      wr(12'hf08, 8'h07);
      u_gct_pin_model.drive(i[0]);
      wr(12'hf07, {1'b1, i[0], 6'h07});
      cyc(30);
      rd(12'hf01, d);
      chk("idle count", d, 8'h01);
      u_gct_pin_model.drive(!i[0]);
      cyc(49);
      u_gct_pin_model.drive(i[0]);
      cyc(49);
      u_gct_pin_model.drive(!i[0]);
      cyc(10);
      rd(12'hf05, d);
      chk("capture", {7'h0, d >= 8'h62 && d <= 8'h68}, 8'h01);
      rd(12'hf01, d);
      chk("recount", {7'h0, d < 8'h20}, 8'h01);
      rd(12'hf06, d);
      chk("cause set", d & 8'h01, 8'h01);
      rd(12'hf08, d);
      chk("capture status", d & 8'h05, 8'h04);
      wr(12'hf08, 8'h07);
      wr(12'hf02, 8'h00);
      wr(12'hf03, 8'h40);
      cyc(100);
      rd(12'hf06, d);
      chk("cause clear", d & 8'h01, 8'h00);
      rd(12'hf08, d);
      chk("compare status", d, 8'h01);
    end
    $display("done: capture compare");
    tally_and_finish;
  end
endmodule // test_gated_capture_timer
bind gct_timer gct_timer_chk u_gct_timer_chk (.sys_clk(sys_clk), .rstn(rstn),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .portA0In(portA0In), .portA0Out(portA0Out),
  .portA0Oe(portA0Oe), .timerIrq(timerIrq));
